// ---- hw/timer_toggle_pulse_output.sv ----
// Timer output stage with toggle and pulse modes
`timescale 1ns/1ps
`include "timer_toggle_pulse_cfg.svh"
module timer_toggle_pulse_output (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	input  wire logic                   mode_pulse,
	input  wire logic                   unit_ms,
	input  wire logic                   trig_from_timer_zero,
	input  wire logic                   master_timer_zero_start,
	input  wire logic [`INTERVAL_W-1:0] interval_wdata,
	input  wire logic [`IDX_W-1:0]      interval_widx,
	input  wire logic                   interval_we,
	input  wire logic [`IDX_W-1:0]      interval_last,
	input  wire logic [`REPC_W-1:0]     repc_wdata,
	input  wire logic                   repc_we,
	input  wire logic                   open_drain_drive,
	input  wire logic                   force_high,
	input  wire logic                   force_low,
	input  wire logic                   invert,
	input  wire logic                   start_cmd,
	input  wire logic                   stop_cmd,
	input  wire logic                   reset_cmd,
	input  wire logic                   pin_in,
	output logic                        pin_out,
	output logic                        pin_oe,
	output logic [1:0]                  state_rd,
	output logic [15:0]                 div_rd,
	output logic [`REPC_W-1:0]          repc_rd
);
	// ------------------------------------------------------------
	// Pin input synchroniser (observation only) and timer zero start synchroniser
	// ------------------------------------------------------------
	logic pin_s1_r, pin_s2_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end else if (ce) begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end
	logic trig_s1_r, trig_s2_r, trig_s3_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_s3_r <= 1'b0;
		end else if (ce) begin
			trig_s1_r <= master_timer_zero_start;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
		end
	end
	wire trig_rise_w = trig_s2_r && !trig_s3_r;

	// ------------------------------------------------------------
	// Interval list and repeat count storage
	// ------------------------------------------------------------
	logic [`INTERVAL_W-1:0] interval_r [`INTERVAL_CNT];
	logic [`REPC_W-1:0]     repc_cfg_r;
	genvar gi;
	generate
		for (gi = 0; gi < `INTERVAL_CNT; gi++) begin : g_int
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b)
					interval_r[gi] <= `INTERVAL_W'(1);
				else if (ce && interval_we && interval_widx == `IDX_W'(gi))
					interval_r[gi] <= interval_wdata;
			end
		end
	endgenerate

	function automatic logic [`REPC_W-1:0] eff_repc(input logic [`REPC_W-1:0] v);
		eff_repc = (v == 7'h00 || v > `REPC_MAX) ? `REPC_MAX : v;
	endfunction : eff_repc

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	timer_toggle_pulse_pkg::run_state_t state_r, state_nxt;
	logic [`IDX_W-1:0]      idx_r, idx_nxt;
	logic [`INTERVAL_W-1:0] ucnt_r, ucnt_nxt;
	logic [`REPC_W-1:0]     rem_r, rem_nxt;
	logic                   lvl_r, lvl_nxt;
	logic                   tick;
	wire running_w = (state_r == timer_toggle_pulse_pkg::ST_FIRST) ||
		(state_r == timer_toggle_pulse_pkg::ST_SECOND);
	wire [`INTERVAL_W-1:0] cur_int_w = interval_r[idx_r];
	wire expire_w = tick && (ucnt_r + `INTERVAL_W'(1) >= cur_int_w);
	wire last_idx_w = (idx_r >= interval_last);
	wire go_w = trig_from_timer_zero ? trig_rise_w : 1'b1;

	unit_tick_gen u_tick (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.run     (running_w),
		.unit_ms (unit_ms),
		.tick    (tick)
	);

	always_comb begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		ucnt_nxt  = ucnt_r;
		rem_nxt   = rem_r;
		lvl_nxt   = lvl_r;
		unique case (state_r)
			timer_toggle_pulse_pkg::ST_IDLE: begin
				if (start_cmd) begin
					state_nxt = timer_toggle_pulse_pkg::ST_WAIT;
					idx_nxt   = '0;
					ucnt_nxt  = '0;
					rem_nxt   = eff_repc(repc_cfg_r);
					if (mode_pulse)
						lvl_nxt = 1'b0;
				end
			end
			timer_toggle_pulse_pkg::ST_WAIT: begin
				if (go_w)
					state_nxt = timer_toggle_pulse_pkg::ST_FIRST;
			end
			timer_toggle_pulse_pkg::ST_FIRST: begin
				if (tick)
					ucnt_nxt = ucnt_r + `INTERVAL_W'(1);
				if (expire_w) begin
					ucnt_nxt = '0;
					if (mode_pulse) begin
						lvl_nxt   = 1'b1;
						idx_nxt   = `IDX_W'(1);
						state_nxt = timer_toggle_pulse_pkg::ST_SECOND;
					end else begin
						lvl_nxt = !lvl_r;
						idx_nxt = last_idx_w ? '0 : idx_r + `IDX_W'(1);
						rem_nxt = rem_r - `REPC_W'(1);
						if (rem_r == `REPC_W'(1))
							state_nxt = timer_toggle_pulse_pkg::ST_IDLE;
					end
				end
			end
			timer_toggle_pulse_pkg::ST_SECOND: begin
				if (tick)
					ucnt_nxt = ucnt_r + `INTERVAL_W'(1);
				if (expire_w) begin
					ucnt_nxt  = '0;
					lvl_nxt   = 1'b0;
					idx_nxt   = '0;
					rem_nxt   = rem_r - `REPC_W'(1);
					state_nxt = (rem_r == `REPC_W'(1)) ? timer_toggle_pulse_pkg::ST_IDLE :
						timer_toggle_pulse_pkg::ST_FIRST;
				end
			end
		endcase
		if (stop_cmd) begin
			state_nxt = timer_toggle_pulse_pkg::ST_IDLE;
			lvl_nxt   = lvl_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= timer_toggle_pulse_pkg::ST_IDLE;
			idx_r      <= '0;
			ucnt_r     <= '0;
			rem_r      <= `REPC_RST;
			lvl_r      <= 1'b0;
			repc_cfg_r <= `REPC_RST;
		end else if (ce) begin
			if (reset_cmd) begin
				state_r    <= timer_toggle_pulse_pkg::ST_IDLE;
				idx_r      <= '0;
				ucnt_r     <= '0;
				rem_r      <= `REPC_RST;
				lvl_r      <= 1'b0;
				repc_cfg_r <= `REPC_RST;
			end else begin
				state_r <= state_nxt;
				idx_r   <= idx_nxt;
				ucnt_r  <= ucnt_nxt;
				rem_r   <= rem_nxt;
				lvl_r   <= lvl_nxt;
				if (repc_we)
					repc_cfg_r <= repc_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin drive and status read-back
	// ------------------------------------------------------------
	wire base_lvl_w = force_high ? 1'b1 : (force_low ? 1'b0 : lvl_r);
	wire pin_lvl_w  = base_lvl_w ^ invert;
	wire pin_oe_w   = open_drain_drive ? !pin_lvl_w : 1'b1;
	logic [1:0] state_code_w;
	always_comb begin
		unique case (state_r)
			timer_toggle_pulse_pkg::ST_IDLE:   state_code_w = `STATE_STOPPED;
			timer_toggle_pulse_pkg::ST_WAIT:   state_code_w = `STATE_WAIT_TRIG;
			timer_toggle_pulse_pkg::ST_FIRST:  state_code_w = `STATE_RUN_FIRST;
			timer_toggle_pulse_pkg::ST_SECOND: state_code_w = `STATE_RUN_SECOND;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out  <= 1'b0;
			pin_oe   <= 1'b1;
			state_rd <= `STATE_STOPPED;
			div_rd   <= `DIV_READ_US;
			repc_rd  <= `REPC_RST;
		end else if (ce) begin
			pin_out  <= open_drain_drive ? 1'b0 : pin_lvl_w;
			pin_oe   <= pin_oe_w;
			state_rd <= state_code_w;
			div_rd   <= unit_ms ? `DIV_READ_MS : `DIV_READ_US;
			repc_rd  <= rem_r;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_toggle_inv;
		@(posedge clk) disable iff (!rst_b)
		(ce && !reset_cmd && !stop_cmd && !mode_pulse && state_r == timer_toggle_pulse_pkg::ST_FIRST
			&& expire_w) |=> lvl_r != $past(lvl_r);
	endproperty
	a_toggle_inv: assert property (p_toggle_inv) else $error("toggle did not invert");
	property p_repc_zero;
		@(posedge clk) disable iff (!rst_b)
		(ce && !reset_cmd && !stop_cmd && state_r == timer_toggle_pulse_pkg::ST_IDLE && start_cmd
			&& repc_cfg_r == 7'h00) |=> rem_r == 7'h40;
	endproperty
	a_repc_zero: assert property (p_repc_zero) else $error("zero repeat not 64");
	property p_wrap;
		@(posedge clk) disable iff (!rst_b)
		(ce && !reset_cmd && !stop_cmd && !mode_pulse && state_r == timer_toggle_pulse_pkg::ST_FIRST
			&& expire_w && last_idx_w) |=> idx_r == 3'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("interval index did not wrap");
	property p_pulse_rise;
		@(posedge clk) disable iff (!rst_b)
		(ce && !reset_cmd && !stop_cmd && mode_pulse && state_r == timer_toggle_pulse_pkg::ST_FIRST
			&& expire_w) |=> lvl_r && state_r == timer_toggle_pulse_pkg::ST_SECOND;
	endproperty
	a_pulse_rise: assert property (p_pulse_rise) else $error("pulse did not rise");
	property p_pulse_end_low;
		@(posedge clk) disable iff (!rst_b)
		(ce && !reset_cmd && !stop_cmd && state_r == timer_toggle_pulse_pkg::ST_SECOND && expire_w)
			|=> !lvl_r;
	endproperty
	a_pulse_end_low: assert property (p_pulse_end_low) else $error("pulse did not end low");
	property p_invert;
		@(posedge clk) disable iff (!rst_b)
		(ce && !open_drain_drive && !force_high && !force_low) |=> pin_out == ($past(lvl_r) ^ $past(invert));
	endproperty
	a_invert: assert property (p_invert) else $error("pin level wrong");
	property p_stop_hold;
		@(posedge clk) disable iff (!rst_b)
		(ce && stop_cmd && !reset_cmd) |=> state_r == timer_toggle_pulse_pkg::ST_IDLE && $stable(lvl_r);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop did not hold");
	property p_reset_cmd;
		@(posedge clk) disable iff (!rst_b)
		(ce && reset_cmd) |=> state_r == timer_toggle_pulse_pkg::ST_IDLE && !lvl_r && rem_r == 7'h00;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset command failed");
	property p_state_rd;
		@(posedge clk) disable iff (!rst_b)
		ce |=> (state_rd == 2'h0) == ($past(state_r) == timer_toggle_pulse_pkg::ST_IDLE);
	endproperty
	a_state_rd: assert property (p_state_rd) else $error("state read mismatch");
	property p_div_rd;
		@(posedge clk) disable iff (!rst_b)
		ce |=> div_rd == ($past(unit_ms) ? 16'hA410 : 16'h002A);
	endproperty
	a_div_rd: assert property (p_div_rd) else $error("unit read wrong");
	property p_self_stop;
		@(posedge clk) disable iff (!rst_b)
		(ce && !reset_cmd && running_w && expire_w && rem_r == 7'h01
			&& !(mode_pulse && state_r == timer_toggle_pulse_pkg::ST_FIRST))
			|=> state_r == timer_toggle_pulse_pkg::ST_IDLE ##1 state_rd == 2'h0;
	endproperty
	a_self_stop: assert property (p_self_stop) else $error("did not stop at zero");
	c_toggle: cover property (@(posedge clk) disable iff (!rst_b) !mode_pulse && running_w && expire_w);
	c_pulse: cover property (@(posedge clk) disable iff (!rst_b)
		state_r == timer_toggle_pulse_pkg::ST_SECOND && expire_w);
	c_trig: cover property (@(posedge clk) disable iff (!rst_b)
		state_r == timer_toggle_pulse_pkg::ST_WAIT && trig_from_timer_zero && trig_rise_w);
	c_open_drain: cover property (@(posedge clk) disable iff (!rst_b) open_drain_drive && !pin_oe);
	c_pin_released: cover property (@(posedge clk) disable iff (!rst_b) open_drain_drive && !pin_oe && pin_s2_r);
endmodule : timer_toggle_pulse_output

// ---- hw/timer_toggle_pulse_cfg.svh ----
// Constants for the timer toggle and pulse output stage
`ifndef TIMER_TOGGLE_PULSE_CFG_SVH
`define TIMER_TOGGLE_PULSE_CFG_SVH
`define CLK_FREQ_HZ        20000000
`define US_PER_S           1000000
`define MS_PER_S           1000
`define US_TICK_CYCLES     (`CLK_FREQ_HZ / `US_PER_S)
`define MS_TICK_CYCLES     (`CLK_FREQ_HZ / `MS_PER_S)
`define INTERVAL_W         15
`define INTERVAL_CNT       8
`define IDX_W              3
`define REPC_W             7
`define REPC_MAX           7'h40
`define REPC_RST           7'h00
`define DIV_READ_US        16'h002A
`define DIV_READ_MS        16'hA410
`define STATE_STOPPED      2'h0
`define STATE_WAIT_TRIG    2'h1
`define STATE_RUN_FIRST    2'h2
`define STATE_RUN_SECOND   2'h3
`endif

// ---- hw/timer_toggle_pulse_pkg.sv ----
// Types for the timer toggle and pulse output stage
package timer_toggle_pulse_pkg;
	typedef enum logic { MODE_TOGGLE, MODE_PULSE } out_mode_t;
	typedef enum logic [1:0] { ST_IDLE, ST_WAIT, ST_FIRST, ST_SECOND } run_state_t;
endpackage : timer_toggle_pulse_pkg

// ---- hw/unit_tick_gen.sv ----
// Prescaler that emits one tick per microsecond or millisecond
`timescale 1ns/1ps
`include "timer_toggle_pulse_cfg.svh"
module unit_tick_gen (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic run,
	input  wire logic unit_ms,
	output logic      tick
);
	localparam int TOP_W = 15;
	localparam logic [TOP_W-1:0] US_TOP = TOP_W'(`US_TICK_CYCLES - 1);
	localparam logic [TOP_W-1:0] MS_TOP = TOP_W'(`MS_TICK_CYCLES - 1);
	logic [TOP_W-1:0] cnt_r;
	wire  [TOP_W-1:0] top_w = unit_ms ? MS_TOP : US_TOP;
	wire              wrap_w = (cnt_r >= top_w);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (ce) begin
			cnt_r <= (!run || wrap_w) ? '0 : cnt_r + 1'b1;
			tick  <= run && wrap_w;
		end
	end
endmodule : unit_tick_gen

// ---- sim/pin_load_model.sv ----
// Load on the timer pin: pull-up resistor that resolves the driven or released pin
`timescale 1ns/1ps
module pin_load_model (
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level
);
	// Released pin floats up to the pull-up level
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : pin_load_model

// ---- sim/timer_toggle_pulse_output_test.sv ----
// Self-checking bench for the timer toggle and pulse output stage
`timescale 1ns/1ps
`include "timer_toggle_pulse_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module timer_toggle_pulse_output_test;
	logic                   clk, rst_b, mode_pulse, unit_ms, trig, tz_start;
	logic [`INTERVAL_W-1:0] iv_wdata;
	logic [`IDX_W-1:0]      iv_widx, iv_last;
	logic                   iv_we, repc_we, od, f_hi, f_lo, inv, start_cmd, stop_cmd, reset_cmd;
	logic [`REPC_W-1:0]     repc_wdata, repc_rd;
	logic                   pin_out, pin_oe, pin_level, lv;
	logic [1:0]             state_rd;
	logic [15:0]            div_rd;
	int                     failures, num_checks, seed, n, t[3], rises;

	timer_toggle_pulse_output u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .mode_pulse(mode_pulse),
		.unit_ms(unit_ms), .trig_from_timer_zero(trig), .master_timer_zero_start(tz_start),
		.interval_wdata(iv_wdata), .interval_widx(iv_widx), .interval_we(iv_we), .interval_last(iv_last),
		.repc_wdata(repc_wdata), .repc_we(repc_we), .open_drain_drive(od), .force_high(f_hi),
		.force_low(f_lo), .invert(inv), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
		.reset_cmd(reset_cmd), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
		.state_rd(state_rd), .div_rd(div_rd), .repc_rd(repc_rd));
	pin_load_model u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

	// ----------------------------------------
	// Clock and helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic finish_test();
		$display("Checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk);
			#1;
		end
	endtask : tick
	task automatic wr_int(input int idx, input int val);
		iv_widx = idx[`IDX_W-1:0];
		iv_wdata = val[`INTERVAL_W-1:0];
		iv_we = 1'b1;
		tick(1);
		iv_we = 1'b0;
		tick(1);
	endtask : wr_int
	task automatic wr_repc(input int val);
		repc_wdata = val[`REPC_W-1:0];
		repc_we = 1'b1;
		tick(1);
		repc_we = 1'b0;
	endtask : wr_repc
	task automatic go();
		start_cmd = 1'b1;
		tick(1);
		start_cmd = 1'b0;
	endtask : go
	// Waits for the pin level to change; cycles counted into n
	task automatic wait_edge(input int lim);
		logic prev;
		prev = pin_level;
		n = 0;
		while (pin_level === prev) begin
			tick(1);
			n++;
			if (n > lim) begin
				failures++;
				$display("Error pin_edge expected change seen none");
				finish_test();
			end
		end
	endtask : wait_edge
	// Gap in cycles for a count of microsecond units, a few cycles of pipeline allowed
	function automatic int gap_seen(input int units, input int cyc);
		return (cyc >= units * 20 - 5 && cyc <= units * 20 + 5) ? units * 20 : cyc;
	endfunction : gap_seen
	function automatic int rnd_units();
		return $unsigned($random(seed)) % 4 + 1;
	endfunction : rnd_units

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 90;
		failures = 0;
		num_checks = 0;
		{rst_b, mode_pulse, unit_ms, trig, tz_start, iv_we, repc_we, od, f_hi, f_lo, inv} = '0;
		{start_cmd, stop_cmd, reset_cmd, iv_wdata, iv_widx, iv_last, repc_wdata} = '0;
		tick(3);
		rst_b = 1'b1;
		tick(1);
		`CHK("state", 2'h0, state_rd)
		`CHK("div", 16'h002A, div_rd)
		`CHK("pin", 1'b0, pin_level)
		unit_ms = 1'b1;
		tick(2);
		`CHK("div", 16'hA410, div_rd)
		unit_ms = 1'b0;
		// Toggle mode: three intervals used in order with wrap, four toggles
		for (int i = 0; i < 3; i++) begin
			t[i] = rnd_units();
			wr_int(i, t[i]);
		end
		iv_last = 3'h2;
		wr_repc(4);
		go();
		for (int k = 0; k < 4; k++) begin
			lv = pin_level;
			wait_edge(200);
			`CHK("gap", t[k % 3] * 20, gap_seen(t[k % 3], n))
			`CHK("pin", ~lv, pin_level)
			tick(1);
			`CHK("repc", `REPC_W'(3 - k), repc_rd)
		end
		tick(5);
		`CHK("state", 2'h0, state_rd)
		// Pulse mode: low for first interval, high for second, twice
		mode_pulse = 1'b1;
		t[0] = rnd_units();
		t[1] = rnd_units();
		wr_int(0, t[0]);
		wr_int(1, t[1]);
		wr_repc(2);
		go();
		for (int r = 0; r < 2; r++) begin
			wait_edge(200);
			`CHK("gap", t[0] * 20, gap_seen(t[0], n))
			`CHK("pin", 1'b1, pin_level)
			`CHK("state", 2'h3, state_rd)
			wait_edge(200);
			`CHK("gap", t[1] * 20, gap_seen(t[1], n))
			`CHK("pin", 1'b0, pin_level)
		end
		tick(5);
		`CHK("state", 2'h0, state_rd)
		// Inverted pulse, inversion acting at once
		inv = 1'b1;
		tick(2);
		`CHK("pin", 1'b1, pin_level)
		wr_repc(1);
		go();
		wait_edge(200);
		`CHK("pin", 1'b0, pin_level)
		wait_edge(200);
		`CHK("gap", t[1] * 20, gap_seen(t[1], n))
		inv = 1'b0;
		tick(2);
		`CHK("pin", 1'b0, pin_level)
		// Forced levels in push-pull and open-drain drive
		f_hi = 1'b1;
		tick(2);
		`CHK("pin", 1'b1, pin_level)
		od = 1'b1;
		tick(2);
		`CHK("oe", 1'b0, pin_oe)
		f_hi = 1'b0;
		f_lo = 1'b1;
		tick(2);
		`CHK("oe", 1'b1, pin_oe)
		`CHK("pin", 1'b0, pin_level)
		{od, f_lo} = 2'b00;
		// Stop after one toggle keeps the level; reset command clears it
		mode_pulse = 1'b0;
		wr_int(0, 4);
		iv_last = 3'h0;
		wr_repc(3);
		go();
		wait_edge(200);
		tick(40);
		stop_cmd = 1'b1;
		tick(1);
		stop_cmd = 1'b0;
		tick(120);
		`CHK("state", 2'h0, state_rd)
		`CHK("pin", 1'b1, pin_level)
		reset_cmd = 1'b1;
		tick(1);
		reset_cmd = 1'b0;
		tick(3);
		`CHK("pin", 1'b0, pin_level)
		`CHK("repc", 7'h00, repc_rd)
		// Start held until timer zero starts
		trig = 1'b1;
		wr_int(0, 1);
		wr_repc(1);
		go();
		tick(10);
		`CHK("state", 2'h1, state_rd)
		tz_start = 1'b1;
		wait_edge(60);
		`CHK("pin", 1'b1, pin_level)
		{tz_start, trig} = 2'b00;
		tick(5);
		`CHK("state", 2'h0, state_rd)
		// Millisecond unit: one toggle after one unit
		unit_ms = 1'b1;
		wr_repc(1);
		go();
		wait_edge(20100);
		`CHK("gap_ms", 1'b1, n >= `MS_TICK_CYCLES - 5 && n <= `MS_TICK_CYCLES + 5)
		`CHK("pin", 1'b0, pin_level)
		unit_ms = 1'b0;
		// Repeat count zero means 64 pulses
		mode_pulse = 1'b1;
		wr_int(1, 1);
		wr_repc(0);
		go();
		tick(3);
		`CHK("repc", 7'h40, repc_rd)
		rises = 0;
		lv = pin_level;
		for (int i = 0; i < 3200 && state_rd !== 2'h0; i++) begin
			tick(1);
			if (pin_level === 1'b1 && lv === 1'b0) rises++;
			lv = pin_level;
		end
		`CHK("pulses", 64, rises)
		`CHK("state", 2'h0, state_rd)
		finish_test();
	end
endmodule : timer_toggle_pulse_output_test
